// File: include/adc_mux_map.svh
// register offsets, field positions, reset values and timing counts
// Functional notes
// R1 - converter result is a read-only data source
// R2 - start bit 0001 begins a conversion
// R3 - done flag sets when conversion finishes
// R4 - code 1000 clears flag, 1001 clears and starts
// R5 - done flag drives interrupt request, status bit 12
// R6 - host saves counter at 52, resumes 53
// R7 - flag low for bit period times width
// R8 - host waits 8us settling after input switch
// R9 - conversion time per variant from table
// R10 - host allows per-variant input settling before start
// R11 - unipolar result left-justified, msb at bit 15
// R12 - channel register readable and writable
// R13 - multiplexer has no functions or status flags
// R14 - multiplexer settles within 1us of write
// R15 - 8, 16, 24 or 32 channels fitted
// R16 - 5-bit channel register wraps modulo 32
// R17 - host never selects unfitted channel
// R18 - flag and request hold until clear command
// R19 - bipolar result two's complement, sign bit 15
// R20 - sense reports flag or inverse, no change
`ifndef ADC_MUX_MAP_SVH
`define ADC_MUX_MAP_SVH
`define OFS_CMD        8'h00
`define OFS_STATUS     8'h04
`define OFS_RESULT     8'h08
`define OFS_CHAN       8'h0C
`define OFS_SENSE      8'h10
`define OFS_CHAN_INC   8'h14
`define OFS_IDENT      8'h18
`define CMD_START_BIT  0
`define CMD_CLEAR_BIT  3
`define ST_DONE_BIT    0
`define ST_BUSY_BIT    1
`define ST_MUXOK_BIT   2
`define ST_INOK_BIT    3
`define SENSE_INV_BIT  0
`define CHAN_RST       5'h00
`define ADC_ADDR_DEF   8'h41
`define MUX_ADDR_DEF   8'h40
`define IRQ_BIT_DEF    4'hC
`define CLK_MHZ        40
`define NS_TO_CYC(ns)  (((ns) * `CLK_MHZ + 999) / 1000)
`define MUX_SETTLE_NS  1000
`define MUX_SETTLE_CYC `NS_TO_CYC(`MUX_SETTLE_NS)
`define CONV_8H_NS     4000
`define CONV_8L_NS     10400
`define CONV_10H_NS    7500
`define CONV_10L_NS    13000
`define CONV_12H_NS    9000
`define CONV_12L_NS    15600
`define SETL_8H_NS     2100
`define SETL_8L_NS     4100
`define SETL_HI_NS     6000
`define SETL_LO_NS     8000
`endif

// File: include/adc_mux_pkg.sv
// shared types of the converter and multiplexer block
package adc_mux_pkg;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_TRIAL, SEQ_DONE} seq_state_t;
	typedef logic [4:0]  chan_t;
	typedef logic [15:0] word_t;
	typedef logic [31:0] wb_data_t;
endpackage

// File: include/conv_if.sv
// control link between the bus side and the approximation sequencer
`timescale 1ns/10ps
interface conv_if #(parameter int W = 10);
	logic         start;
	logic         comp;
	logic         busy;
	logic         done;
	logic [W-1:0] code;
	logic [W-1:0] guess;
	modport ctrl (output start, output comp, input busy, input done,
		input code, input guess);
	modport seq (input start, input comp, output busy, output done,
		output code, output guess);
endinterface

// File: src/adc_sar_seq.sv
// successive-approximation bit sequencer driven by a comparator level
`timescale 1ns/10ps
module adc_sar_seq #(
	parameter int W       = 10,
	parameter int BIT_CYC = 52
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	conv_if.seq       cv
);
	import adc_mux_pkg::*;
	localparam int            CW        = $clog2(BIT_CYC + 1);
	localparam int            IW        = $clog2(W);
	localparam logic [CW-1:0] TICK_LAST = CW'(BIT_CYC - 1);
	localparam logic [IW-1:0] IDX_TOP   = IW'(W - 1);
	localparam logic [W-1:0]  FIRST     = {1'b1, {(W-1){1'b0}}};

	// the comparator arrives through two flops, so a bit needs three cycles
	if (W < 2 || BIT_CYC < 3) begin : bad_cfg
		$error("sequencer needs two bits and three cycles per bit");
	end

	seq_state_t    state_r;
	logic [CW-1:0] tick_r;
	logic [IW-1:0] idx_r;
	logic [W-1:0]  sar_r;
	logic [W-1:0]  code_r;
	logic          bit_end;
	logic          take;

	assign take    = (state_r == SEQ_IDLE) && cv.start;
	assign bit_end = (state_r == SEQ_TRIAL) && (tick_r == '0);

	// every bit trial lasts BIT_CYC cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= SEQ_IDLE;
			tick_r  <= '0;
			idx_r   <= '0;
		end else begin
			unique case (state_r)
				SEQ_IDLE: begin
					if (take) begin // R2
						state_r <= SEQ_TRIAL;
						tick_r  <= TICK_LAST;
						idx_r   <= IDX_TOP;
					end
				end
				SEQ_TRIAL: begin
					if (bit_end) begin // R7
						tick_r <= TICK_LAST;
						idx_r  <= idx_r - 1'b1;
						if (idx_r == '0)
							state_r <= SEQ_DONE;
					end else
						tick_r <= tick_r - 1'b1;
				end
				SEQ_DONE: state_r <= SEQ_IDLE;
				default:  state_r <= SEQ_IDLE;
			endcase
		end
	end

	// comparator high means the guess is not above the input: keep the bit
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sar_r <= '0;
		else if (take)
			sar_r <= FIRST;
		else if (bit_end) begin
			if (!cv.comp)
				sar_r[idx_r] <= 1'b0;
			if (idx_r != '0)
				sar_r[idx_r - 1'b1] <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			code_r <= '0;
		else if (bit_end && idx_r == '0)
			code_r <= {sar_r[W-1:1], sar_r[0] & cv.comp};
	end

	assign cv.busy  = (state_r != SEQ_IDLE);
	assign cv.done  = (state_r == SEQ_DONE);
	assign cv.code  = code_r;
	assign cv.guess = sar_r;

	chk_first_guess: assert property (@(posedge clk_i) disable iff (rst_i) // R2
		take |=> (cv.guess == FIRST) && cv.busy)
		else $error("first trial is not the top bit");
	chk_done_single: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		cv.done |=> !cv.done && !cv.busy)
		else $error("done lasted more than one cycle");
endmodule

// File: src/adc_mux_operator.sv
// converter and channel multiplexer control behind a wishbone slave
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "adc_mux_map.svh"
module adc_mux_operator #(
	parameter int         RES_BITS     = 10,
	parameter bit         HIGH_SPEED   = 1'b0,
	parameter bit         BIPOLAR      = 1'b0,
	parameter int         MUX_CHANNELS = 32,
	parameter logic [7:0] ADC_SYS_ADDR = `ADC_ADDR_DEF,
	parameter logic [7:0] MUX_SYS_ADDR = `MUX_ADDR_DEF,
	parameter logic [3:0] IRQ_BIT      = `IRQ_BIT_DEF
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire adc_mux_pkg::wb_data_t wb_dat_i,
	output adc_mux_pkg::wb_data_t      wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic                  comp_i,
	output logic [RES_BITS-1:0]        dac_guess_o,
	output adc_mux_pkg::chan_t         mux_chan_o,
	output logic [MUX_CHANNELS-1:0]    mux_switch_o,
	output logic                       mux_settled_o,
	output logic                       conversion_done_flag_o,
	output logic                       irq_o,
	output adc_mux_pkg::word_t         isr_request_o
);
	import adc_mux_pkg::*;

	function automatic int variant_ns(input int bits, input bit hs,
		input bit settle);
		int ns;
		ns = 0;
		if (settle) begin
			if (bits == 8)
				ns = hs ? `SETL_8H_NS : `SETL_8L_NS;
			else
				ns = hs ? `SETL_HI_NS : `SETL_LO_NS;
		end else begin
			if (bits == 8)
				ns = hs ? `CONV_8H_NS : `CONV_8L_NS;
			else if (bits == 10)
				ns = hs ? `CONV_10H_NS : `CONV_10L_NS;
			else
				ns = hs ? `CONV_12H_NS : `CONV_12L_NS;
		end
		return ns;
	endfunction

	function automatic logic hit(input logic [7:0] adr,
		input logic [7:0] ofs);
		return adr[7:2] == ofs[7:2];
	endfunction

	// R9
	localparam int CONV_NS    = variant_ns(RES_BITS, HIGH_SPEED, 1'b0);
	localparam int SETTLE_NS  = variant_ns(RES_BITS, HIGH_SPEED, 1'b1);
	localparam int CONV_CYC   = `NS_TO_CYC(CONV_NS);
	localparam int BIT_CYC    = CONV_CYC / RES_BITS;
	localparam int SETTLE_CYC = `NS_TO_CYC(SETTLE_NS);
	localparam int MSW        = $clog2(`MUX_SETTLE_CYC + 1);
	localparam int ISW        = $clog2(SETTLE_CYC + 1);
	localparam logic [MSW-1:0] MUX_LOAD = MSW'(`MUX_SETTLE_CYC);
	localparam logic [ISW-1:0] IN_LOAD  = ISW'(SETTLE_CYC);
	localparam int PAD = 16 - RES_BITS;

	// R15
	if (!(RES_BITS == 8 || RES_BITS == 10 || RES_BITS == 12) ||
		!(MUX_CHANNELS == 8 || MUX_CHANNELS == 16 ||
		MUX_CHANNELS == 24 || MUX_CHANNELS == 32)) begin : bad_cfg
		$error("unsupported resolution or channel count");
	end

	conv_if #(.W(RES_BITS)) cv ();

	adc_sar_seq #(
		.W       (RES_BITS),
		.BIT_CYC (BIT_CYC)
	) u_seq (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cv    (cv.seq)
	);

	logic           ack_r;
	wb_data_t       rd_r;
	logic           comp_meta_r;
	logic           comp_sync_r;
	logic           done_flag_r;
	logic           sense_inv_r;
	word_t          result_r;
	chan_t          chan_r;
	chan_t          chan_nxt;
	logic [MSW-1:0] mux_cnt_r;
	logic [ISW-1:0] in_cnt_r;
	logic           irq_r;
	word_t          isr_r;
	logic           wr_go;
	logic           rd_req;
	logic           cmd_wr;
	logic           clr_cmd;
	logic           start_go;
	logic           chan_wr;
	logic           chan_inc;
	logic           skip;
	wb_data_t       rd_nxt;
	logic [RES_BITS-1:0] code_x;

	// one wait state: ack in the cycle after the request appears
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
	end

	// writes land on the edge where the master sees ack
	assign wr_go    = wb_cyc_i && wb_stb_i && wb_we_i && ack_r &&
		wb_sel_i[0];
	assign rd_req   = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
	assign cmd_wr   = wr_go && hit(wb_adr_i, `OFS_CMD);
	assign clr_cmd  = cmd_wr && wb_dat_i[`CMD_CLEAR_BIT]; // R4
	// a start while busy is dropped; the running conversion completes
	assign start_go = cmd_wr && wb_dat_i[`CMD_START_BIT] &&
		!cv.busy; // R2
	// R13
	assign chan_wr  = wr_go && hit(wb_adr_i, `OFS_CHAN);
	assign chan_inc = wr_go && hit(wb_adr_i, `OFS_CHAN_INC);
	assign skip     = done_flag_r ^ sense_inv_r; // R20

	assign cv.start = start_go;
	assign cv.comp  = comp_sync_r;

	// comparator is an analog pin: two flops before the sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			comp_meta_r <= 1'b0;
			comp_sync_r <= 1'b0;
		end else begin
			comp_meta_r <= comp_i;
			comp_sync_r <= comp_meta_r;
		end
	end

	// the done event wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			done_flag_r <= 1'b0;
		else if (cv.done)
			done_flag_r <= 1'b1; // R3
		else if (clr_cmd)
			done_flag_r <= 1'b0; // R18
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			sense_inv_r <= 1'b0;
		else if (wr_go && hit(wb_adr_i, `OFS_SENSE))
			sense_inv_r <= wb_dat_i[`SENSE_INV_BIT];
	end

	// bipolar codes come offset binary; flipping the msb gives the sign
	assign code_x = cv.code ^ {BIPOLAR, {(RES_BITS-1){1'b0}}}; // R19

	// result only changes at completion; bus writes never reach it
	always_ff @(posedge clk_i) begin
		if (rst_i)
			result_r <= '0;
		else if (cv.done)
			result_r <= {code_x, {PAD{1'b0}}}; // R11
	end

	always_comb begin
		chan_nxt = chan_r;
		if (chan_wr)
			chan_nxt = wb_dat_i[4:0]; // R12
		else if (chan_inc)
			chan_nxt = chan_r + 5'h01; // R16
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			chan_r <= `CHAN_RST;
		else
			chan_r <= chan_nxt;
	end

	// only fitted channels get a switch; higher codes leave the input open
	for (genvar g = 0; g < MUX_CHANNELS; g++) begin : sw
		always_ff @(posedge clk_i) begin
			if (rst_i)
				mux_switch_o[g] <= 1'b0;
			else
				mux_switch_o[g] <= (chan_nxt == 5'(g)); // R15
		end
	end

	// switch settle and converter front-end settle after a channel change
	always_ff @(posedge clk_i) begin
		if (rst_i)
			mux_cnt_r <= '0;
		else if (chan_wr || chan_inc)
			mux_cnt_r <= MUX_LOAD; // R14
		else if (mux_cnt_r != '0)
			mux_cnt_r <= mux_cnt_r - 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			in_cnt_r <= '0;
		else if (chan_wr || chan_inc)
			in_cnt_r <= IN_LOAD; // R10
		else if (in_cnt_r != '0)
			in_cnt_r <= in_cnt_r - 1'b1; // R8
	end

	// the request holds as long as the flag does
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_r <= 1'b0;
			isr_r <= '0;
		end else begin
			irq_r <= done_flag_r; // R5
			isr_r <= done_flag_r ? (16'h0001 << IRQ_BIT) : 16'h0000;
		end
	end

	always_comb begin
		rd_nxt = '0;
		if (hit(wb_adr_i, `OFS_STATUS)) begin
			rd_nxt[`ST_DONE_BIT]  = done_flag_r;
			rd_nxt[`ST_BUSY_BIT]  = cv.busy;
			rd_nxt[`ST_MUXOK_BIT] = (mux_cnt_r == '0);
			rd_nxt[`ST_INOK_BIT]  = (in_cnt_r == '0);
		end else if (hit(wb_adr_i, `OFS_RESULT))
			rd_nxt = {16'h0000, result_r}; // R1
		else if (hit(wb_adr_i, `OFS_CHAN))
			rd_nxt = {27'h0000000, chan_r};
		else if (hit(wb_adr_i, `OFS_SENSE))
			rd_nxt[0] = skip;
		else if (hit(wb_adr_i, `OFS_IDENT))
			rd_nxt = {12'h000, IRQ_BIT, MUX_SYS_ADDR, ADC_SYS_ADDR};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rd_r <= '0;
		else if (rd_req)
			rd_r <= rd_nxt;
	end

	assign wb_ack_o               = ack_r;
	assign wb_dat_o               = rd_r;
	assign dac_guess_o            = cv.guess;
	assign mux_chan_o             = chan_r;
	assign mux_settled_o          = (mux_cnt_r == '0);
	assign conversion_done_flag_o = done_flag_r;
	assign irq_o                  = irq_r;
	assign isr_request_o          = isr_r;

	// helper: cycles spent busy since the last start
	logic [9:0] busy_cnt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i || start_go)
			busy_cnt_r <= '0;
		else if (cv.busy)
			busy_cnt_r <= busy_cnt_r + 10'h001;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	chk_conv_length: assert property ( // R7
		cv.done |-> busy_cnt_r == 10'(CONV_CYC))
		else $error("conversion length differs from its variant");
	chk_flag_sets: assert property ( // R3
		cv.done |=> done_flag_r ##1 irq_r)
		else $error("flag or request missing after done");
	chk_flag_clear: assert property ( // R4
		clr_cmd && !cv.done |=> !done_flag_r)
		else $error("clear command left the flag set");
	chk_flag_holds: assert property ( // R18
		done_flag_r && !clr_cmd |=> done_flag_r && irq_r)
		else $error("flag dropped without a clear command");
	chk_start_runs: assert property ( // R2
		start_go |=> cv.busy && busy_cnt_r == 10'h000)
		else $error("start command did not begin a conversion");
	chk_result_just: assert property ( // R11
		cv.done |=> result_r[15 -: RES_BITS] == $past(code_x) &&
		result_r == (result_r >> PAD) << PAD)
		else $error("result is not left-justified");
	chk_result_ro: assert property ( // R1
		wr_go && hit(wb_adr_i, `OFS_RESULT) && !cv.done |=>
		$stable(result_r))
		else $error("a bus write changed the result");
	chk_chan_wrap: assert property ( // R16
		chan_inc && chan_r == 5'h1F |=> chan_r == 5'h00)
		else $error("channel did not wrap to zero");
	chk_mux_settle: assert property ( // R14
		chan_wr |-> ##[1:41] (mux_settled_o || chan_wr || chan_inc))
		else $error("multiplexer settle exceeded its time");
	chk_mux_low: assert property ( // R14
		chan_wr ##1 (!chan_wr && !chan_inc)[*8] |-> !mux_settled_o)
		else $error("settled reported too early");
	chk_sense_read: assert property ( // R20
		$rose(wb_ack_o) && !wb_we_i && hit(wb_adr_i, `OFS_SENSE) |->
		wb_dat_o[0] == $past(skip))
		else $error("sense answer does not match the flag");
	chk_one_switch: assert property ( // R15
		$onehot0(mux_switch_o))
		else $error("more than one channel switch closed");
	chk_irq_bit: assert property ( // R5
		irq_r |-> isr_request_o == (16'h0001 << IRQ_BIT))
		else $error("request on the wrong status bit");
	chk_start_refused: assert property ( // R2
		cmd_wr && wb_dat_i[`CMD_START_BIT] && cv.busy |=>
		busy_cnt_r != 10'h000)
		else $error("start while busy restarted the conversion");
	chk_clear_start: assert property ( // R4
		clr_cmd && start_go |=> !done_flag_r && cv.busy)
		else $error("combined clear and start failed");
	chk_flag_low_run: assert property ( // R7
		cv.busy && !cv.done && !done_flag_r |=> !done_flag_r)
		else $error("flag rose before the conversion ended");
	chk_result_hold: assert property ( // R1
		!cv.done |=> $stable(result_r))
		else $error("result changed outside completion");
	chk_bipolar_sign: assert property ( // R19
		cv.done |=>
		result_r[15] == ($past(cv.code[RES_BITS-1]) ^ BIPOLAR))
		else $error("result sign bit is wrong");
	chk_mux_no_flag: assert property ( // R13
		(chan_wr || chan_inc) && !cv.done |=>
		done_flag_r == $past(done_flag_r))
		else $error("multiplexer write moved the flag");
	chk_chan_write: assert property ( // R12
		chan_wr |=> chan_r == $past(wb_dat_i[4:0]))
		else $error("channel register missed a write");
	chk_in_settle: assert property ( // R10
		chan_wr || chan_inc |=> in_cnt_r == IN_LOAD)
		else $error("input settle count not restarted");
	chk_sense_keeps: assert property ( // R20
		wr_go && hit(wb_adr_i, `OFS_SENSE) && !cv.done |=>
		done_flag_r == $past(done_flag_r))
		else $error("sense setting moved the flag");
endmodule

// File: tb/analog_src.sv
// analog source and comparator model in front of the converter ladder
`timescale 1ns/10ps
module analog_src #(
	parameter int W = 10
) (
	input  wire logic [W-1:0] guess_i,
	input  wire logic [4:0]   chan_i,
	output logic              comp_o
);
	logic [W-1:0] level;

	// each channel carries its own fixed level, so a wrong channel shows up
	assign level = W'(chan_i * 31 + 7);
	// comparator keeps the trial bit while the guess does not exceed the input
	assign comp_o = (guess_i <= level);
endmodule

// File: tb/testbench.sv
// self-checking bench for the converter and multiplexer control
`timescale 1ns/10ps
`include "adc_mux_map.svh"
module testbench;
	import adc_mux_pkg::*;
	logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, comp;
	logic        flag, irq, settled;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [9:0]  guess;
	logic [31:0] sw;
	wb_data_t    wb_dat_w, wb_dat_r, rd;
	chan_t       chan;
	word_t       interrupt_status_register;
	int          err_count, n_compared, cyc_n, t0;

	adc_mux_operator u_dut (
		.clk_i                  (clk_i),
		.rst_i                  (rst_i),
		.wb_cyc_i               (wb_cyc),
		.wb_stb_i               (wb_stb),
		.wb_we_i                (wb_we),
		.wb_adr_i               (wb_adr),
		.wb_sel_i               (wb_sel),
		.wb_dat_i               (wb_dat_w),
		.wb_dat_o               (wb_dat_r),
		.wb_ack_o               (wb_ack),
		.comp_i                 (comp),
		.dac_guess_o            (guess),
		.mux_chan_o             (chan),
		.mux_switch_o           (sw),
		.mux_settled_o          (settled),
		.conversion_done_flag_o (flag),
		.irq_o                  (irq),
		.isr_request_o          (interrupt_status_register)
	);

	analog_src u_src (
		.guess_i (guess),
		.chan_i  (chan),
		.comp_o  (comp)
	);

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) cyc_n <= cyc_n + 1;

	task automatic give_verdict;
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic miss(input string m);
		err_count++;
		$display("MISMATCH %0t %s", $time, m);
	endtask

	task automatic cut(input string m);
		miss(m);
		give_verdict();
	endtask

	task automatic chk_word(input wb_data_t got, input wb_data_t exp,
		input string m);
		n_compared++;
		if (got !== exp)
			miss(m);
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string m);
		n_compared++;
		if (got !== exp)
			miss(m);
	endtask

	task automatic chk_range(input int n, input int lo, input int hi,
		input string m);
		n_compared++;
		if (n < lo || n > hi)
			miss(m);
	endtask

	// classic single cycle: hold everything until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [7:0] a,
		input wb_data_t d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		wb_cyc   <= 1'b1;
		wb_stb   <= 1'b1;
		wb_we    <= we;
		wb_adr   <= a;
		wb_dat_w <= d;
		wb_sel   <= s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (wb_ack !== 1'b1)
			cut("no bus ack");
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input wb_data_t d);
		wb_xfer(1'b1, a, d, 4'hF);
	endtask

	task automatic rdw(input logic [7:0] a);
		wb_xfer(1'b0, a, 32'h0, 4'hF);
	endtask

	task automatic wait_flag;
		int n;
		n = 0;
		while (flag !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		if (flag !== 1'b1)
			cut("flag never set");
	endtask

	task automatic t_reset;
		chk_bit(flag, 1'b0, "flag after reset");
		chk_bit(irq, 1'b0, "irq after reset");
		chk_word(sw, 32'h1, "switch after reset");
		rdw(`OFS_IDENT);
		chk_word(rd, {12'h0, 4'hC, 8'h40, 8'h41}, "ident");
		rdw(8'h3C);
		chk_word(rd, 32'h0, "unmapped read");
	endtask

	task automatic t_mux;
		int n;
		wr(`OFS_CHAN, 32'h1F);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (settled !== 1'b1 && n < 100);
		chk_range(n, 38, 42, "mux settle time");
		chk_word(sw, 32'h80000000, "switch 31");
		rdw(`OFS_CHAN);
		chk_word(rd, 32'h1F, "chan readback");
		chk_bit(flag, 1'b0, "mux write moved flag");
		wr(`OFS_CHAN_INC, 32'h0);
		rdw(`OFS_CHAN);
		chk_word(rd, 32'h0, "chan wrap");
		wb_xfer(1'b1, `OFS_CHAN, 32'h3, 4'hE);
		rdw(`OFS_CHAN);
		chk_word(rd, 32'h0, "write without lane 0");
		wr(`OFS_CHAN, 32'h5);
		@(posedge clk_i);
		chk_word({27'h0, chan}, 32'h5, "chan pins");
	endtask

	// channel 5 level 162, left-justified by six places
	task automatic t_convert;
		int i;
		i = 0;
		do begin
			rdw(`OFS_STATUS);
			i++;
		end while (rd[`ST_INOK_BIT] !== 1'b1 && i < 300);
		if (rd[`ST_INOK_BIT] !== 1'b1)
			cut("input never settled");
		wr(`OFS_CMD, 32'h1);
		t0 = cyc_n;
		repeat (100) @(posedge clk_i);
		rdw(`OFS_STATUS);
		chk_bit(rd[`ST_BUSY_BIT], 1'b1, "busy");
		wr(`OFS_CMD, 32'h1);
		wait_flag();
		chk_range(cyc_n - t0, 520, 530, "conversion time");
		@(posedge clk_i);
		chk_bit(irq, 1'b1, "irq");
		chk_word({16'h0, interrupt_status_register}, 32'h1000, "status bit");
		rdw(`OFS_RESULT);
		chk_word(rd, 32'h2880, "result");
		wr(`OFS_SENSE, 32'h1);
		rdw(`OFS_SENSE);
		chk_bit(rd[0], 1'b0, "sense inverted");
		wr(`OFS_SENSE, 32'h0);
		rdw(`OFS_SENSE);
		chk_bit(rd[0], 1'b1, "sense plain");
		wr(`OFS_RESULT, 32'hFFFF);
		rdw(`OFS_RESULT);
		chk_word(rd, 32'h2880, "result written");
		chk_bit(flag, 1'b1, "flag held");
		chk_bit(irq, 1'b1, "irq held");
		wr(`OFS_CMD, 32'h8);
		@(posedge clk_i);
		chk_bit(flag, 1'b0, "clear");
		@(posedge clk_i);
		chk_bit(irq, 1'b0, "irq cleared");
		wr(`OFS_CMD, 32'h1);
		wait_flag();
		wr(`OFS_CMD, 32'h9);
		t0 = cyc_n;
		@(posedge clk_i);
		chk_bit(flag, 1'b0, "clear and start");
		wait_flag();
		chk_range(cyc_n - t0, 520, 530, "second conversion");
		rdw(`OFS_RESULT);
		chk_word(rd, 32'h2880, "second result");
	endtask

	initial begin
		err_count  = 0;
		n_compared = 0;
		cyc_n      = 0;
		rst_i      = 1'b1;
		wb_cyc     = 1'b0;
		wb_stb     = 1'b0;
		wb_we      = 1'b0;
		wb_adr     = 8'h0;
		wb_sel     = 4'h0;
		wb_dat_w   = 32'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		@(posedge clk_i);
		t_reset();
		t_mux();
		t_convert();
		give_verdict();
	end
endmodule
